// File: inc/xcvr_ctrl_pkg.sv
// shared constants, frame layout and state encodings for the transceiver control link
package xcvr_ctrl_pkg;

  // frame header, vector bit 0 goes out first: 0, 1, 1
  localparam logic [2:0] HEADER_BITS = 3'h6;
  // transceiver addresses
  localparam logic [2:0] OWN_ADDR = 3'h1;
  localparam logic [2:0] BCAST_ADDR = 3'h7;

  // register indices
  localparam logic [3:0] IDX_COMMON = 4'h0;
  localparam logic [3:0] IDX_MODE = 4'h1;
  localparam logic [3:0] IDX_POWER = 4'h2;
  localparam logic [3:0] IDX_RESET = 4'hD;
  localparam logic [3:0] IDX_EXT = 4'hF;

  // reset values of the control registers
  localparam logic [4:0] CTRL0_DEFAULT = 5'h14;
  localparam logic [7:0] CTRL1_DEFAULT = 8'h00;
  localparam logic [7:0] CTRL2_DEFAULT = 8'h70;
  // value loaded when a mode write is refused
  localparam logic [7:0] CTRL1_FALLBACK = 8'h00;
  // only the upper nibble of the power register exists
  localparam logic [7:0] CTRL2_MASK = 8'hF0;

  // common control bit positions
  localparam int PM_BIT = 0;
  localparam int OEN_BIT = 1;
  localparam int LED_BIT = 2;
  localparam int ACK_PULSE_ENABLE_BIT = 4;

  // accepted infrared mode codes
  localparam logic [7:0] MODE_SLOW = 8'h00;
  localparam logic [7:0] MODE_MEDIUM = 8'h01;
  localparam logic [7:0] MODE_FAST = 8'h02;
  localparam logic [7:0] MODE_SLOW_ALT = 8'h03;
  localparam logic [7:0] MODE_VERY_FAST = 8'h05;
  localparam logic [7:0] MODE_SLOW_ALT2 = 8'h08;

  // consecutive low write-line samples that force recovery
  localparam logic [4:0] LOW_RESET_EDGES = 5'h1E;
  // answer slots skipped by read frames
  localparam logic [4:0] READ_SLOTS = 5'h08;
  localparam logic [4:0] EXT_READ_SLOTS = 5'h10;

  // link clock timing of the controller end
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCLK_HALF_NS = 800;
  localparam int SCLK_HALF_CYCLES = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // controller register map (byte offsets)
  localparam logic [3:0] REG_FRAME = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RECOVER = 4'h8;
  // frame register fields
  localparam int FRAME_DATA_LSB = 0;
  localparam int FRAME_IDX_LSB = 8;
  localparam int FRAME_ADDR_LSB = 12;
  localparam int FRAME_SPECIAL_BIT = 15;
  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ACK_BIT = 1;

  // frame lengths in link clock cycles, trailing answer slot included
  localparam logic [5:0] LEN_WRITE = 6'h16;
  localparam logic [5:0] LEN_SPECIAL = 6'h0D;
  localparam logic [5:0] LEN_RECOVER = 6'h21;
  // remaining count while the last stop bit is on the line
  localparam logic [5:0] ACK_SAMPLE_LEFT = 6'h02;

  // device frame decoder states
  typedef enum logic [2:0] {
    ST_HDR,
    ST_IDX,
    ST_ADR,
    ST_CT,
    ST_DAT,
    ST_SKIP,
    ST_STOP
  } dev_state_t;

endpackage

// File: inc/xcvr_link_if.sv
// serial control link between controller and transceiver
`timescale 1ns/1ps
interface xcvr_link_if;
  logic sclk; // link clock from the controller
  logic transmit_write_line; // controller data, shared with transmit
  logic receive_answer_line; // device answer, shared with receive
  logic receive_answer_oe_n; // low while the device drives the answer line

  modport ctrl_end (
    output sclk,
    output transmit_write_line,
    input receive_answer_line,
    input receive_answer_oe_n
  );

  modport xcvr_end (
    input sclk,
    input transmit_write_line,
    output receive_answer_line,
    output receive_answer_oe_n
  );
endinterface

// File: logic/link_sync.sv
// two flip-flop synchroniser for a small group of foreign-domain levels
`timescale 1ns/1ps
module link_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  import xcvr_ctrl_pkg::*;

  // first stage feeds only the second stage
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t q; // registered state
  sync_state_t d; // next state

  // shift one stage per clock
  always_comb begin
    d = q;
    d.meta = async_i;
    d.stable = q.meta;
  end

  // synchronous reset to zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.stable;
endmodule

// File: logic/serial_control_slave.sv
// transceiver end: frame decoder, control registers and acknowledge driver
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

// Overview of operation
// - undecodable commands leave registers unchanged
// - bad read frames give no answer
// - bad write frames never acknowledge
// - broadcast reads give no answer
// - no reaction means answer line untouched
// - thirty low samples reset state and registers
// - sample write line on link rising edge
// - fields travel least significant bit first
// - accept own or broadcast address only
// - follow every frame to its end
// - special command restores all register defaults
// - other special codes are invalid
// - write frame layout header index address type data stops
// - escape index only for extended reads
// - write data sets addressed register
// - writes arrive on clock and write lines
// - extended command forms are unsupported
// - one line each way
// - controller keeps link clock below limit
// - acknowledge pulse when both enables set
// - bad mode value loads fallback, no acknowledge
module serial_control_slave (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic receiver_data_i,
  xcvr_link_if.xcvr_end link,
  output logic power_mode_o,
  output logic led_enable_o,
  output logic [7:0] ir_mode_o,
  output logic [3:0] led_power_o
);
  import xcvr_ctrl_pkg::*;

  // whole device state in one record
  typedef struct packed {
    dev_state_t st; // decoder position
    logic [4:0] cnt; // bit counter inside a field
    logic [3:0] idx; // register index being gathered
    logic [2:0] adr; // transceiver address being gathered
    logic rw; // command type bit, 1 for write
    logic [7:0] data; // data byte being gathered
    logic stop_bad; // a stop bit was high
    logic [4:0] low_cnt; // consecutive low samples
    logic sclk_prev; // last synchronised link clock level
    logic [4:0] ctrl0; // common control register
    logic [7:0] ctrl1; // infrared mode register
    logic [7:0] ctrl2; // power level register
    logic ack; // acknowledge slot active
    logic rx; // answer line level
    logic oe_n; // answer line enable, low drives
  } dev_q_t;

  dev_q_t q; // registered state
  dev_q_t d; // next state

  logic [2:0] sync_in; // link clock, write line, receiver
  logic [2:0] synced; // the same after two flops
  logic sclk_s; // synchronised link clock
  logic wbit; // synchronised write line
  logic rxd_s; // synchronised receiver output
  logic rise; // link clock rising edge seen
  logic frame_end; // last stop bit taken
  logic ok; // command executed successfully
  logic recover; // line-low recovery fires

  // accepted mode codes; anything else is refused
  function automatic logic mode_valid(input logic [7:0] v);
    case (v)
      MODE_SLOW, MODE_MEDIUM, MODE_FAST, MODE_SLOW_ALT, MODE_VERY_FAST, MODE_SLOW_ALT2:
        mode_valid = 1'b1;
      default:
        mode_valid = 1'b0;
    endcase
  endfunction

  // counter that stops at the recovery threshold
  function automatic logic [4:0] sat_inc(input logic [4:0] v);
    sat_inc = (v == LOW_RESET_EDGES) ? v : v + 5'h01;
  endfunction

  // the link clock is foreign and may idle, so it is sampled, not used as a clock
  assign sync_in = {receiver_data_i, link.transmit_write_line, link.sclk};

  link_sync #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(sync_in),
    .sync_o(synced)
  );

  assign sclk_s = synced[0];
  assign wbit = synced[1];
  assign rxd_s = synced[2];

  // decoder and registers stepped once per link rising edge, answer line refreshed every clock
  always_comb begin
    d = q;
    ok = 1'b0;
    frame_end = 1'b0;
    recover = 1'b0;
    rise = sclk_s & ~q.sclk_prev;
    d.sclk_prev = sclk_s;
    if (rise) begin
      // acknowledge lasts exactly one link clock cycle
      d.ack = 1'b0;
      // low-line watchdog runs in every state
      d.low_cnt = wbit ? 5'h00 : sat_inc(q.low_cnt);
      recover = ~wbit && (sat_inc(q.low_cnt) == LOW_RESET_EDGES);
      case (q.st)
        ST_HDR: begin
          // hunt for 0,1,1 before decoding anything
          if (wbit == HEADER_BITS[q.cnt[1:0]]) begin
            if (q.cnt == 5'h02) begin
              d.st = ST_IDX;
              d.cnt = 5'h00;
            end else begin
              d.cnt = q.cnt + 5'h01;
            end
          end else begin
            // a stray 0 may itself start a header
            d.cnt = wbit ? 5'h00 : 5'h01;
          end
        end
        ST_IDX: begin
          d.idx = {wbit, q.idx[3:1]};
          if (q.cnt == 5'h03) begin
            d.st = ST_ADR;
            d.cnt = 5'h00;
          end else begin
            d.cnt = q.cnt + 5'h01;
          end
        end
        ST_ADR: begin
          d.adr = {wbit, q.adr[2:1]};
          d.stop_bad = 1'b0;
          d.cnt = 5'h00;
          if (q.cnt == 5'h02) begin
            // the special command has no type bit, stops follow directly
            d.st = (q.idx == IDX_RESET) ? ST_STOP : ST_CT;
          end else begin
            d.cnt = q.cnt + 5'h01;
          end
        end
        ST_CT: begin
          d.rw = wbit;
          if (wbit) begin
            d.st = ST_DAT;
            d.cnt = 5'h00;
          end else begin
            // reads are followed but never answered
            d.st = ST_SKIP;
            d.cnt = (q.idx == IDX_EXT) ? EXT_READ_SLOTS - 5'h01 : READ_SLOTS - 5'h01;
          end
        end
        ST_DAT: begin
          d.data = {wbit, q.data[7:1]};
          if (q.cnt == 5'h07) begin
            d.st = ST_STOP;
            d.cnt = 5'h00;
          end else begin
            d.cnt = q.cnt + 5'h01;
          end
        end
        ST_SKIP: begin
          if (q.cnt == 5'h00) begin
            d.st = ST_STOP;
          end else begin
            d.cnt = q.cnt - 5'h01;
          end
        end
        ST_STOP: begin
          d.stop_bad = q.stop_bad | wbit;
          if (q.cnt == 5'h01) begin
            d.st = ST_HDR;
            d.cnt = 5'h00;
            frame_end = 1'b1;
          end else begin
            d.cnt = q.cnt + 5'h01;
          end
        end
        default: begin
          d.st = ST_HDR;
          d.cnt = 5'h00;
        end
      endcase
      // act only on clean frames for this device
      if (frame_end && !(q.stop_bad || wbit)
          && (q.adr == OWN_ADDR || q.adr == BCAST_ADDR)) begin
        if (q.idx == IDX_RESET) begin
          // the only special command implemented
          d.ctrl0 = CTRL0_DEFAULT;
          d.ctrl1 = CTRL1_DEFAULT;
          d.ctrl2 = CTRL2_DEFAULT;
          ok = 1'b1;
        end else if (q.rw) begin
          // read frames fall through here without effect
          case (q.idx)
            IDX_COMMON: begin
              d.ctrl0 = q.data[4:0];
              ok = 1'b1;
            end
            IDX_MODE: begin
              if (mode_valid(q.data)) begin
                d.ctrl1 = q.data;
                ok = 1'b1;
              end else begin
                d.ctrl1 = CTRL1_FALLBACK;
              end
            end
            IDX_POWER: begin
              d.ctrl2 = q.data & CTRL2_MASK;
              ok = 1'b1;
            end
            default: begin
              // unused and escape indices change nothing
              ok = 1'b0;
            end
          endcase
        end
      end
      // acknowledge only individual, successful, enabled writes
      if (ok && q.rw | (q.idx == IDX_RESET) && q.adr == OWN_ADDR
          && d.ctrl0[ACK_PULSE_ENABLE_BIT] && d.ctrl0[OEN_BIT]) begin
        d.ack = 1'b1;
      end
    end
    if (recover) begin
      // back to header hunt with default registers
      d.st = ST_HDR;
      d.cnt = 5'h00;
      d.ctrl0 = CTRL0_DEFAULT;
      d.ctrl1 = CTRL1_DEFAULT;
      d.ctrl2 = CTRL2_DEFAULT;
      d.ack = 1'b0;
    end
    // answer line: acknowledge, else receiver unless disconnected by the enable
    d.oe_n = ~d.ctrl0[OEN_BIT];
    d.rx = d.ack ? 1'b0 : (d.ctrl0[ACK_PULSE_ENABLE_BIT] ? 1'b1 : rxd_s);
  end

  // register the whole state; defaults as after power-up
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.st <= ST_HDR;
      q.ctrl0 <= CTRL0_DEFAULT;
      q.ctrl1 <= CTRL1_DEFAULT;
      q.ctrl2 <= CTRL2_DEFAULT;
      q.rx <= 1'b1;
      q.oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // every output straight from the state register
  assign link.receive_answer_line = q.rx;
  assign link.receive_answer_oe_n = q.oe_n;
  assign power_mode_o = q.ctrl0[PM_BIT];
  assign led_enable_o = q.ctrl0[LED_BIT];
  assign ir_mode_o = q.ctrl1;
  assign led_power_o = q.ctrl2[7:4];
endmodule

// File: logic/serial_control_master.sv
// controller end: register port, frame builder and link clock divider
`timescale 1ns/1ps
module serial_control_master (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [15:0] rdata_o,
  xcvr_link_if.ctrl_end link
);
  import xcvr_ctrl_pkg::*;

  // whole controller state in one record
  typedef struct packed {
    logic [32:0] frame; // bits still to send, bit 0 on the line
    logic [5:0] nbits; // link cycles left, zero when idle
    logic [3:0] div; // half period counter
    logic sclk; // link clock level
    logic tx; // write line level
    logic ack_seen; // sticky acknowledge flag
    logic [15:0] rdata; // read answer
  } ctrl_q_t;

  ctrl_q_t q; // registered state
  ctrl_q_t d; // next state
  logic [1:0] ans_s; // answer line and enable, synchronised
  logic busy; // a frame is on the link

  // the answer pins come from the other end, so synchronise them
  link_sync #(
    .W(2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({link.receive_answer_oe_n, link.receive_answer_line}),
    .sync_o(ans_s)
  );

  assign busy = (q.nbits != 6'h00);

  // register port, frame start and bit shifting
  always_comb begin
    d = q;
    d.rdata = 16'h0000;
    if (re_i && addr_i == REG_STATUS) begin
      d.rdata[STAT_BUSY_BIT] = busy;
      d.rdata[STAT_ACK_BIT] = q.ack_seen;
    end
    // clear first so that a same-cycle acknowledge wins
    if (we_i && addr_i == REG_STATUS && wdata_i[STAT_ACK_BIT]) begin
      d.ack_seen = 1'b0;
    end
    if (busy) begin
      d.div = q.div + 4'h1;
      if (q.div == 4'(SCLK_HALF_CYCLES - 1)) begin
        d.div = 4'h0;
        d.sclk = ~q.sclk;
        if (q.sclk) begin
          // falling edge: the device samples on rising, so data moves here
          if (q.nbits == ACK_SAMPLE_LEFT && !ans_s[0] && !ans_s[1]) begin
            d.ack_seen = 1'b1;
          end
          d.frame = q.frame >> 1;
          d.nbits = q.nbits - 6'h01;
          d.tx = (q.nbits == 6'h01) ? 1'b1 : q.frame[1];
        end
      end
    end else if (we_i && addr_i == REG_FRAME) begin
      // special or write frame, least significant bit first
      d.div = 4'h0;
      // trailing one sits just above the last stop bit, the rest of the vector is zero
      if (wdata_i[FRAME_SPECIAL_BIT]) begin
        d.frame = {21'h00_0001, 2'b00, wdata_i[FRAME_ADDR_LSB +: 3], IDX_RESET, HEADER_BITS};
        d.nbits = LEN_SPECIAL;
      end else begin
        d.frame = {12'h001, 2'b00, wdata_i[FRAME_DATA_LSB +: 8], 1'b1,
                   wdata_i[FRAME_ADDR_LSB +: 3], wdata_i[FRAME_IDX_LSB +: 4], HEADER_BITS};
        d.nbits = LEN_WRITE;
      end
      d.tx = 1'b0;
    end else if (we_i && addr_i == REG_RECOVER) begin
      // hold the write line low long enough to force device recovery
      d.div = 4'h0;
      d.frame = {1'b1, 32'h0000_0000};
      d.nbits = LEN_RECOVER;
      d.tx = 1'b0;
    end
  end

  // register the whole state; idle link has clock low and data high
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.tx <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign link.sclk = q.sclk;
  assign link.transmit_write_line = q.tx;
endmodule

// File: testbench/xcvr_link_sva.sv
// concurrent checks on the serial link between controller and transceiver
`timescale 1ns/1ps
module xcvr_link_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic transmit_write_line,
  input wire logic receive_answer_line,
  input wire logic receive_answer_oe_n
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // answer line pulled low while driven: an acknowledge
  sequence ack_start;
    $fell(receive_answer_line) && !receive_answer_oe_n;
  endsequence
  // write line drops after a quiet link clock: a new frame
  sequence frame_start;
    $fell(transmit_write_line) && !sclk && !$past(sclk);
  endsequence
  // first link rise after the frame start
  sequence first_rise;
    ##[7:9] $rose(sclk);
  endsequence
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("link clock high phase not eight cycles");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk [*8])
    else $error("link clock low phase too short");
  AST_TX_SETUP: assert property ($changed(transmit_write_line) |-> !sclk)
    else $error("write line moved while link clock high");
  AST_TX_HOLD: assert property ($rose(sclk) |->
      $stable(transmit_write_line) throughout sclk [*8])
    else $error("write line not held over the high phase");
  AST_ACK_SHORT: assert property (ack_start |-> ##[1:24] receive_answer_line)
    else $error("acknowledge pulse too long");
  AST_ACK_IN_STOP: assert property (ack_start |-> !transmit_write_line && sclk)
    else $error("acknowledge outside the last stop bit");
  AST_OE_AT_END: assert property ($changed(receive_answer_oe_n) |->
      !transmit_write_line)
    else $error("answer enable changed outside frame end");
  AST_FRAME_HEADER: assert property (frame_start |->
      !transmit_write_line throughout first_rise)
    else $error("frame does not open with a zero bit");
endmodule

// File: testbench/tb.sv
// self-checking bench: controller register port driving the transceiver end
`timescale 1ns/1ps
module tb;
  import xcvr_ctrl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0; // held low at start
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [15:0] rdata_o;
  logic receiver_data_i = 1'b1; // photodiode level, idle high
  logic power_mode_o;
  logic led_enable_o;
  logic [7:0] ir_mode_o;
  logic [3:0] led_power_o;
  int err_count = 0;
  int check_count = 0;
  logic [31:0] rd_q; // last read result
  logic sclk_prev = 1'b0;
  logic cap_q [$]; // write line seen at link rises
  logic [7:0] modes [6] = '{MODE_SLOW, MODE_MEDIUM, MODE_FAST, MODE_SLOW_ALT,
    MODE_VERY_FAST, MODE_SLOW_ALT2};
  logic [3:0] bad_idx [4] = '{4'h3, 4'hC, 4'hE, IDX_EXT}; // undecodable writes

  xcvr_link_if u_xcvr_link_if ();
  serial_control_master u_serial_control_master (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .link(u_xcvr_link_if.ctrl_end));
  serial_control_slave u_serial_control_slave (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .receiver_data_i(receiver_data_i), .link(u_xcvr_link_if.xcvr_end),
    .power_mode_o(power_mode_o), .led_enable_o(led_enable_o), .ir_mode_o(ir_mode_o),
    .led_power_o(led_power_o));
  xcvr_link_sva u_xcvr_link_sva (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sclk(u_xcvr_link_if.sclk), .transmit_write_line(u_xcvr_link_if.transmit_write_line),
    .receive_answer_line(u_xcvr_link_if.receive_answer_line),
    .receive_answer_oe_n(u_xcvr_link_if.receive_answer_oe_n));

  // 100 ns period
  always #50 clk_i = ~clk_i;

  // record the write line at each link rise, as the device samples it
  always @(posedge clk_i) begin
    sclk_prev <= u_xcvr_link_if.sclk;
    if (u_xcvr_link_if.sclk && !sclk_prev) begin
      cap_q.push_back(u_xcvr_link_if.transmit_write_line);
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // register port read data
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask
  // transceiver outputs and link wires
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    cmp(got, exp);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // one-cycle write strobe, then one idle edge so a following write never
  // lowers and raises the strobe in the same time step
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic reg_rd(input logic [3:0] a);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 rd_q = {16'h0000, rdata_o};
    @(posedge clk_i);
  endtask

  // start a frame and poll busy under a bound
  task automatic send_frame(input logic [3:0] a, input logic [15:0] w);
    logic done;
    done = 1'b0;
    cap_q.delete();
    reg_wr(a, w);
    for (int i = 0; i < 400 && !done; i++) begin
      reg_rd(REG_STATUS);
      done = (rd_q[STAT_BUSY_BIT] === 1'b0);
    end
    if (!done) begin
      err_count++;
    end
    repeat (4) @(posedge clk_i);
  endtask

  // frame through the port, then the bits seen on the wire
  task automatic xfer(input logic [15:0] w);
    logic [31:0] got;
    logic [31:0] exp;
    int n;
    send_frame(REG_FRAME, w);
    n = w[FRAME_SPECIAL_BIT] ? 12 : 21;
    exp = w[FRAME_SPECIAL_BIT] ? {20'h0_0000, 2'b00, w[14:12], 4'hD, 3'b110} :
      {11'h000, 2'b00, w[7:0], 1'b1, w[14:12], w[11:8], 3'b110};
    got = '0;
    for (int i = 0; i < n; i++) begin
      got[i] = (i < cap_q.size()) ? cap_q[i] : 1'bx;
    end
    chk_pin(got, exp);
  endtask

  task automatic chk_state(input logic pm, input logic led, input logic [7:0] m,
      input logic [3:0] p);
    chk_pin({18'h0_0000, power_mode_o, led_enable_o, ir_mode_o, led_power_o},
      {18'h0_0000, pm, led, m, p});
  endtask
  task automatic chk_dflt();
    chk_state(CTRL0_DEFAULT[PM_BIT], CTRL0_DEFAULT[LED_BIT], CTRL1_DEFAULT,
      CTRL2_DEFAULT[7:4]);
  endtask
  // acknowledge flag, cleared after each look
  task automatic ack_chk(input logic e);
    reg_rd(REG_STATUS);
    chk_reg({31'h0000_0000, rd_q[STAT_ACK_BIT]}, {31'h0000_0000, e});
    reg_wr(REG_STATUS, 16'h0002);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk_dflt();
    reg_rd(4'hC);
    chk_reg(rd_q, 32'h0000_0000);
    reg_rd(REG_STATUS);
    chk_reg(rd_q, 32'h0000_0000);
    $display("test port done");
    foreach (modes[k]) begin
      xfer({1'b0, OWN_ADDR, IDX_MODE, modes[k]});
      chk_state(1'b0, 1'b1, modes[k], 4'h7);
      ack_chk(1'b0);
    end
    xfer({1'b0, OWN_ADDR, IDX_MODE, 8'h04});
    chk_state(1'b0, 1'b1, CTRL1_FALLBACK, 4'h7);
    $display("test modes done");
    xfer({1'b0, 3'h2, IDX_MODE, MODE_FAST});
    chk_state(1'b0, 1'b1, 8'h00, 4'h7);
    foreach (bad_idx[k]) begin
      xfer({1'b0, OWN_ADDR, bad_idx[k], MODE_VERY_FAST});
      chk_state(1'b0, 1'b1, 8'h00, 4'h7);
    end
    xfer({1'b0, BCAST_ADDR, IDX_MODE, MODE_FAST});
    chk_state(1'b0, 1'b1, MODE_FAST, 4'h7);
    $display("test address done");
    xfer({1'b0, OWN_ADDR, IDX_COMMON, 8'h13});
    chk_state(1'b1, 1'b0, MODE_FAST, 4'h7);
    ack_chk(1'b1);
    xfer({1'b0, OWN_ADDR, IDX_POWER, 8'hA5});
    chk_state(1'b1, 1'b0, MODE_FAST, 4'hA);
    ack_chk(1'b1);
    xfer({1'b0, OWN_ADDR, IDX_MODE, 8'h04});
    ack_chk(1'b0);
    xfer({1'b0, BCAST_ADDR, IDX_MODE, MODE_MEDIUM});
    ack_chk(1'b0);
    xfer({1'b0, 3'h4, IDX_MODE, MODE_FAST});
    ack_chk(1'b0);
    receiver_data_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk_pin({31'h0000_0000, u_xcvr_link_if.receive_answer_line}, 32'h0000_0001);
    receiver_data_i <= 1'b1;
    xfer({1'b0, OWN_ADDR, IDX_COMMON, 8'h00});
    receiver_data_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk_pin({31'h0000_0000, u_xcvr_link_if.receive_answer_line}, 32'h0000_0000);
    chk_pin({31'h0000_0000, u_xcvr_link_if.receive_answer_oe_n}, 32'h0000_0001);
    receiver_data_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk_pin({31'h0000_0000, u_xcvr_link_if.receive_answer_line}, 32'h0000_0001);
    $display("test acknowledge done");
    xfer({1'b1, OWN_ADDR, 12'h000});
    chk_dflt();
    xfer({1'b0, OWN_ADDR, IDX_MODE, MODE_VERY_FAST});
    send_frame(REG_RECOVER, 16'h0000);
    chk_dflt();
    xfer({1'b0, OWN_ADDR, IDX_MODE, MODE_SLOW_ALT});
    chk_state(1'b0, 1'b1, MODE_SLOW_ALT, 4'h7);
    $display("test reset done");
    report_and_stop();
  end

  // hang guard, well beyond the expected run
  initial begin
    repeat (60000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end
endmodule
